//--- scg_pkg.sv
package scg_pkg;

    // ==========================================================
    // Clock rates
    localparam int unsigned MCLK_MHZ = 250;
    localparam int unsigned OSC_THRESH_MHZ = 5;
    localparam int unsigned THRESH_CYCLES = MCLK_MHZ / OSC_THRESH_MHZ;
    localparam int unsigned PERIOD_W = 12;
    localparam int unsigned NUM_DIV = 5;

    // ==========================================================
    // Register map
    localparam int unsigned ADDR_W = 18;
    localparam logic [15:0] SCC_INDEX = 16'hFF3A;
    localparam logic [15:0] STATUS_INDEX = 16'hFF3B;
    localparam logic [7:0] SCC_RESET = 8'h00;
    localparam logic [7:0] SCC_WMASK = 8'hC7;
    localparam int unsigned OUT_DIS_BIT = 7;
    localparam int unsigned RSVD_BIT = 6;
    localparam int unsigned SEL_MSB = 2;
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned STAT_FAST_BIT = 31;

    // ==========================================================
    // Bus master clock selections
    typedef enum logic [2:0] {
        SEL_FULL = 3'h0,
        SEL_DIV2 = 3'h1,
        SEL_DIV4 = 3'h2,
        SEL_DIV8 = 3'h3,
        SEL_DIV16 = 3'h4,
        SEL_DIV32 = 3'h5
    } scg_sel_type;

endpackage : scg_pkg

//--- scg_clk_if.sv
interface scg_clk_if;
    logic phi_tick;
    logic [scg_pkg::NUM_DIV-1:0] div_tick;
    logic [2:0] select;
    logic bus_tick;

    modport divider (input phi_tick, output div_tick);
    modport selector (input phi_tick, input div_tick, input select,
        output bus_tick);
    modport top (output phi_tick, output select, input div_tick,
        input bus_tick);
endinterface : scg_clk_if

//--- scg_divider.sv
module scg_divider (
    input wire logic mclk,
    input wire logic rst_b,
    scg_clk_if.divider clk_if
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [scg_pkg::NUM_DIV-1:0] count;
    } scg_div_state_type;

    scg_div_state_type state_q;
    scg_div_state_type state_d;

    always_comb begin
        state_d = state_q;
        if (clk_if.phi_tick) begin
            state_d.count = state_q.count + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // One tick per 2, 4, 8, 16, 32 system clock ticks
    genvar g;
    generate
        for (g = 0; g < scg_pkg::NUM_DIV; g++) begin : g_div
            assign clk_if.div_tick[g] = clk_if.phi_tick
                && (&state_q.count[g:0]);
        end
    endgenerate

endmodule : scg_divider

//--- scg_selector.sv
module scg_selector (
    scg_clk_if.selector clk_if
);

    // ==========================================================
    // Bus master tick choice
    always_comb begin
        case (clk_if.select)
            scg_pkg::SEL_FULL: clk_if.bus_tick = clk_if.phi_tick;
            scg_pkg::SEL_DIV2: clk_if.bus_tick = clk_if.div_tick[0];
            scg_pkg::SEL_DIV4: clk_if.bus_tick = clk_if.div_tick[1];
            scg_pkg::SEL_DIV8: clk_if.bus_tick = clk_if.div_tick[2];
            scg_pkg::SEL_DIV16: clk_if.bus_tick = clk_if.div_tick[3];
            scg_pkg::SEL_DIV32: clk_if.bus_tick = clk_if.div_tick[4];
            default: clk_if.bus_tick = clk_if.phi_tick;
        endcase
    end

endmodule : scg_selector

//--- scg_system_clock_generator.sv
// Summary of operation
// - Reset and hard standby zero the register; soft standby keeps it.
// - Bit 7 clear puts the clock on the pin; bit 7 set holds the pin high.
// - In soft standby the pin is high, in hard standby it floats.
// - Bit 6 reads back what is written; software writes only zero to it.
// - Bits 5 to 3 read as zero and ignore writes.
// - Select zero, the reset value, gives the bus master the full clock.
// - Select 1 to 5 gives the bus master the clock over 2, 4, 8, 16, 32.
// - A divider makes the clock over 2, 4, 8, 16 and 32.
// - The bus master clock is picked only by the present select field.
// - Oscillator duty is corrected at or above the threshold frequency.
// - The register is decoded at its own index, readable and writable.
// - Only the bus master runs slow; other modules keep the full clock.
module scg_system_clock_generator (
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator and standby
    input wire logic osc_in,
    input wire logic hw_standby_b,
    input wire logic sw_standby,
    // Clock pin
    output logic clock_pin_o,
    output logic clock_pin_oe_b,
    // Clock ticks for consumers
    output logic phi_level,
    output logic module_tick,
    output logic bus_tick
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] osc_sync;
        logic [2:0] stby_sync;
        logic osc_lvl;
        logic stby_lvl_b;
        logic [scg_pkg::PERIOD_W-1:0] cnt;
        logic [scg_pkg::PERIOD_W-1:0] period;
        logic fast;
        logic [scg_pkg::PERIOD_W-1:0] gen_cnt;
        logic gen_lvl;
        logic phi_lvl;
        logic [7:0] system_clock_control;
        logic [31:0] rdata;
        logic slverr;
        logic pin_o;
        logic pin_oe_b;
    } scg_top_state_type;

    localparam logic [scg_pkg::PERIOD_W-1:0] THRESH =
        scg_pkg::PERIOD_W'(scg_pkg::THRESH_CYCLES);
    localparam logic [scg_pkg::PERIOD_W-1:0] CNT_MAX = '1;

    scg_top_state_type state_q;
    scg_top_state_type state_d;

    scg_clk_if clk_if ();

    logic osc_new;
    logic osc_rise;
    logic phi_new;
    logic [15:0] index;
    logic hit_ctrl;
    logic hit_stat;
    logic setup;
    logic wr_access;
    logic [7:0] wmask;

    // ==========================================================
    // Bus decode
    assign index = paddr[scg_pkg::ADDR_W-1:2];
    assign hit_ctrl = (index == scg_pkg::SCC_INDEX)
        && (paddr[1:0] == 2'h0);
    assign hit_stat = (index == scg_pkg::STATUS_INDEX)
        && (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite && hit_ctrl && pstrb[0];
    assign wmask = scg_pkg::SCC_WMASK;

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        osc_new = state_q.osc_lvl;
        phi_new = state_q.phi_lvl;
        osc_rise = 1'b0;

        // Three-stage input sampling
        state_d.osc_sync = {state_q.osc_sync[1:0], osc_in};
        state_d.stby_sync = {state_q.stby_sync[1:0], hw_standby_b};
        if (state_q.osc_sync[1] == state_q.osc_sync[2]) begin
            osc_new = state_q.osc_sync[2];
        end
        if (state_q.stby_sync[1] == state_q.stby_sync[2]) begin
            state_d.stby_lvl_b = state_q.stby_sync[2];
        end
        state_d.osc_lvl = osc_new;
        osc_rise = osc_new && !state_q.osc_lvl;

        // Oscillator period measurement
        if (osc_rise) begin
            state_d.cnt = '0;
            state_d.period = state_q.cnt + 1'b1;
            state_d.fast = (state_q.cnt < THRESH);
        end else if (state_q.cnt != CNT_MAX) begin
            state_d.cnt = state_q.cnt + 1'b1;
        end

        // Regenerated half-high, half-low clock
        if (osc_rise) begin
            state_d.gen_cnt = '0;
            state_d.gen_lvl = 1'b1;
        end else begin
            if (state_q.gen_cnt != CNT_MAX) begin
                state_d.gen_cnt = state_q.gen_cnt + 1'b1;
            end
            if ((state_q.gen_cnt + 1'b1) >= (state_q.period >> 1)) begin
                state_d.gen_lvl = 1'b0;
            end
        end

        // System clock level
        if (state_q.fast) begin
            phi_new = state_d.gen_lvl;
        end else begin
            phi_new = osc_new;
        end
        state_d.phi_lvl = phi_new;

        // Control register
        if (wr_access) begin
            state_d.system_clock_control =
                pwdata[7:0] & wmask;
        end

        // APB read data, captured in the setup cycle
        if (setup) begin
            state_d.rdata = '0;
            state_d.slverr = !(hit_ctrl || hit_stat);
            if (hit_ctrl) begin
                state_d.rdata[7:0] =
                    state_q.system_clock_control & wmask;
            end else if (hit_stat) begin
                state_d.rdata[scg_pkg::PERIOD_W-1:0] = state_q.period;
                state_d.rdata[scg_pkg::STAT_FAST_BIT] = state_q.fast;
            end
        end

        // Clock pin
        state_d.pin_oe_b = 1'b0;
        if (!state_q.stby_lvl_b) begin
            state_d.pin_oe_b = 1'b1;
            state_d.pin_o = 1'b1;
        end else if (sw_standby) begin
            state_d.pin_o = 1'b1;
        end else if (state_q.system_clock_control[scg_pkg::OUT_DIS_BIT]) begin
            state_d.pin_o = 1'b1;
        end else begin
            state_d.pin_o = phi_new;
        end

        // Hardware standby clears the register, software standby keeps it
        if (!state_q.stby_lvl_b) begin
            state_d.system_clock_control = scg_pkg::SCC_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= '0;
            state_q.osc_sync <= 3'h7;
            state_q.stby_sync <= 3'h7;
            state_q.stby_lvl_b <= 1'b1;
            state_q.osc_lvl <= 1'b1;
            state_q.phi_lvl <= 1'b1;
            state_q.system_clock_control <= scg_pkg::SCC_RESET;
            state_q.pin_o <= 1'b1;
            state_q.pin_oe_b <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Divider and bus master clock selection
    assign clk_if.phi_tick = state_d.phi_lvl && !state_q.phi_lvl;
    assign clk_if.select = state_q.system_clock_control
        [scg_pkg::SEL_MSB:scg_pkg::SEL_LSB];

    scg_divider u_divider (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_if(clk_if.divider)
    );

    scg_selector u_selector (
        .clk_if(clk_if.selector)
    );

    // ==========================================================
    // Outputs
    assign prdata = state_q.rdata;
    assign pready = 1'b1;
    assign pslverr = state_q.slverr && psel && penable;
    assign clock_pin_o = state_q.pin_o;
    assign clock_pin_oe_b = state_q.pin_oe_b;
    assign phi_level = state_q.phi_lvl;
    assign module_tick = clk_if.phi_tick;
    assign bus_tick = clk_if.bus_tick;

endmodule : scg_system_clock_generator

//--- scg_checker.sv
module scg_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic hw_standby_b,
    input wire logic sw_standby,
    input wire logic clock_pin_o,
    input wire logic clock_pin_oe_b,
    input wire logic phi_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================
    // Register shadow
    localparam logic [17:0] SCC_A = 18'h3FCE8;
    logic [7:0] sh_q;
    logic hit;
    assign hit = (paddr[17:2] == scg_pkg::SCC_INDEX
        || paddr[17:2] == scg_pkg::STATUS_INDEX) && paddr[1:0] == 2'h0;
    always_ff @(posedge mclk) begin
        if (!rst_b || !hw_standby_b)
            sh_q <= 8'h00;
        else if (psel && penable && pwrite && paddr == SCC_A && pstrb[0])
            sh_q <= pwdata[7:0] & scg_pkg::SCC_WMASK;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence rd_s;
        psel && penable && !pwrite && paddr == SCC_A;
    endsequence
    sequence run_s;
        (hw_standby_b && !sw_standby && !sh_q[7]) [*8];
    endsequence
    read_value_a:
        assert property (rd_s |-> prdata == {24'h0, sh_q})
        else $error("read data wrong");
    bad_addr_a:
        assert property (psel && penable && !hit |-> pslverr)
        else $error("no error on unmapped");
    good_addr_a:
        assert property (psel && penable && hit |-> !pslverr)
        else $error("error on mapped");
    err_phase_a:
        assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    hw_pin_a:
        assert property (!hw_standby_b [*8]
            |-> clock_pin_oe_b && clock_pin_o)
        else $error("pin not floating");
    sw_pin_a:
        assert property (sw_standby [*4] |-> clock_pin_o && !clock_pin_oe_b)
        else $error("pin not high");
    pin_high_a:
        assert property (sh_q[7] [*4] |-> clock_pin_o)
        else $error("pin not held high");
    pin_follow_a:
        assert property (run_s |-> clock_pin_o == phi_level)
        else $error("pin not following");
endmodule : scg_checker

//--- scg_osc_model.sv
module scg_osc_model (
    input wire logic mclk,
    input wire logic [7:0] half,
    input wire logic hold_high,
    output logic osc
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================
    // Clock source
    logic osc_q = 1'b1;
    logic [7:0] cnt_q = 8'h00;
    assign osc = osc_q;
    always @(posedge mclk) begin
        if (hold_high) begin
            osc_q <= 1'b1;
            cnt_q <= 8'h00;
        end else if (cnt_q >= half - 8'h01) begin
            osc_q <= ~osc_q;
            cnt_q <= 8'h00;
        end else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule : scg_osc_model

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================
    // Bench
    localparam logic [17:0] SCC_A = 18'h3FCE8;
    localparam logic [17:0] ST_A = 18'h3FCEC;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] half;
    logic osc, hold, hw_standby_b, sw_standby, pin_o, pin_oe_b;
    logic phi_level, module_tick, bus_tick;
    int error_cnt, n_tests, cyc, nm, nb, nc;
    scg_system_clock_generator dut (.mclk(mclk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_in(osc), .hw_standby_b(hw_standby_b),
        .sw_standby(sw_standby), .clock_pin_o(pin_o),
        .clock_pin_oe_b(pin_oe_b), .phi_level(phi_level),
        .module_tick(module_tick), .bus_tick(bus_tick));
    scg_osc_model osc_m (.mclk(mclk), .half(half), .hold_high(hold),
        .osc(osc));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [17:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ticks();
        do @(posedge mclk); while (module_tick !== 1'b1);
        nm = 0;
        nb = 0;
        nc = 0;
        while (nm < 64) begin
            @(posedge mclk);
            nc++;
            nm += int'(module_tick === 1'b1);
            nb += int'(bus_tick === 1'b1);
        end
    endtask : ticks
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        half = 8'h0A;
        hold = 1'b0;
        hw_standby_b = 1'b1;
        sw_standby = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        apb(1'b0, SCC_A, 32'h0, 4'hF);
        check(rd, 32'h0);
        check({31'h0, pin_oe_b}, 32'h0);
        $display("reset test done");
        apb(1'b1, SCC_A, 32'hBF, 4'hF);
        repeat (2) @(posedge mclk);
        check({30'h0, pin_oe_b, pin_o}, 32'h1);
        apb(1'b0, SCC_A, 32'h0, 4'hF);
        check(rd, 32'h87);
        apb(1'b1, SCC_A, 32'h0, 4'h0);
        apb(1'b0, SCC_A, 32'h0, 4'hF);
        check(rd, 32'h87);
        apb(1'b0, 18'h3FCF0, 32'h0, 4'hF);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, ST_A, 32'hFFFFFFFF, 4'hF);
        check({31'h0, err}, 32'h0);
        repeat (100) @(posedge mclk);
        apb(1'b0, ST_A, 32'h0, 4'hF);
        check({19'h0, rd[31], rd[11:0]}, 32'h1014);
        $display("register test done");
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, SCC_A, 32'(s), 4'hF);
            ticks();
            check(32'(nb), 32'(64 >> ((s > 5) ? 0 : s)));
            check(32'(nc), 32'd1280);
        end
        $display("select test done");
        half <= 8'h28;
        repeat (400) @(posedge mclk);
        apb(1'b0, ST_A, 32'h0, 4'hF);
        check({19'h0, rd[31], rd[11:0]}, 32'h0050);
        apb(1'b1, SCC_A, 32'h3, 4'hF);
        hold <= 1'b1;
        sw_standby <= 1'b1;
        repeat (10) @(posedge mclk);
        check({30'h0, pin_oe_b, pin_o}, 32'h1);
        sw_standby <= 1'b0;
        hold <= 1'b0;
        apb(1'b0, SCC_A, 32'h0, 4'hF);
        check(rd, 32'h3);
        hw_standby_b <= 1'b0;
        hold <= 1'b1;
        repeat (12) @(posedge mclk);
        check({30'h0, pin_oe_b, pin_o}, 32'h3);
        hw_standby_b <= 1'b1;
        hold <= 1'b0;
        repeat (10) @(posedge mclk);
        apb(1'b0, SCC_A, 32'h0, 4'hF);
        check(rd, 32'h0);
        $display("standby test done");
        end_sim();
    end
endmodule : testbench
bind scg_system_clock_generator scg_checker chk (.mclk(mclk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pslverr(pslverr), .hw_standby_b(hw_standby_b),
    .sw_standby(sw_standby), .clock_pin_o(clock_pin_o),
    .clock_pin_oe_b(clock_pin_oe_b), .phi_level(phi_level));
